// file: hdl/dtf_framer.sv
`timescale 1ns/1ns
`include "dtf_map.svh"

// Overview of operation
// - Emit unbroken stream of 188-byte packets; the code stalls mid-packet while frame or service bytes are late.
// - Each packet is 4-byte header plus 184 payload.
// - Header PID marks data packets versus others.
// - Mixing other services optional, framer picks order.
// - Header, optional pointer byte, 183/184 payload bytes.
// - Timestamps count 10.24 MHz master clock ticks.
// - Timestamp jitter under 500 ns peak-to-peak.
// - Timestamp fixed at hand-over, no modulator delay.
// - Count difference tracks elapsed time within 500 ns.
// - Modulator jitter reduces the 500 ns allowance.
// - Sync byte 0x47, identifier 0x1ffe for data.
// - Adaptation control 01, priority 0, scrambling 00.
// - Start flag set puts pointer in fifth byte.
// - Gaps between frames filled with 0xff.
module dtf_framer
   import dtf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] mac_data,
   input wire logic mac_ts,
   input wire logic mac_eof,
   input wire logic mac_valid,
   output logic mac_ready,
   input wire logic svc_enable,
   input wire logic [7:0] svc_data,
   input wire logic svc_sop,
   input wire logic svc_valid,
   output logic svc_ready,
   input wire logic mclk_tick,
   output logic [7:0] tx_data,
   output logic tx_sop,
   output logic tx_valid,
   input wire logic tx_ready
);
   // ---------------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------------
   localparam logic [7:0] LAST_IDX = 8'(`DTF_PKT_LEN - 1);
   localparam logic [7:0] HDR_LAST = 8'(`DTF_HDR_LEN - 1);
   localparam logic [7:0] PTR_IDX = 8'(`DTF_PTR_POS);
   localparam int SYS_PER_TICK = `DTF_SYS_CLK_HZ / `DTF_MASTER_CLK_HZ;
   localparam int JITTER_CYC = (`DTF_JITTER_NS * (`DTF_SYS_CLK_HZ / 1000000)) / 1000;

   // ---------------------------------------------------------------------
   // Header byte builder
   // ---------------------------------------------------------------------
   // Builds header byte idx for a given identifier, start flag and counter.
   function automatic logic [7:0] hdr_byte(
      input logic [1:0] idx,
      input logic [12:0] pid,
      input logic start_flag,
      input logic [3:0] cc
   );
      logic [7:0] b;
      b = `DTF_SYNC_BYTE;
      unique case (idx)
         2'd0: b = `DTF_SYNC_BYTE;
         2'd1: b = {`DTF_TEI_OFF, start_flag, `DTF_PRIORITY_OFF, pid[12:8]};
         2'd2: b = pid[7:0];
         2'd3: b = {`DTF_SCRAMBLE_OFF, `DTF_AFC_PAYLOAD_ONLY, cc};
      endcase
      return b;
   endfunction : hdr_byte

   // ---------------------------------------------------------------------
   // Input and output buffers
   // ---------------------------------------------------------------------
   logic mb_valid;
   logic mb_take;
   logic [9:0] mb_data;
   logic sb_valid;
   logic sb_take;
   logic [8:0] sb_data;
   logic ob_ready;
   logic emit;
   logic [7:0] emit_byte;
   logic emit_sop;
   logic [8:0] tx_word;

   // Data bytes with their timestamp and end-of-frame marks.
   dtf_skid #(.W(10)) u_mac_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .s_valid(mac_valid),
      .s_ready(mac_ready),
      .s_data({mac_eof, mac_ts, mac_data}),
      .m_valid(mb_valid),
      .m_ready(mb_take),
      .m_data(mb_data)
   );

   // Packets of the other service, already 188 bytes long.
   dtf_skid #(.W(9)) u_svc_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .s_valid(svc_valid),
      .s_ready(svc_ready),
      .s_data({svc_sop, svc_data}),
      .m_valid(sb_valid),
      .m_ready(sb_take),
      .m_data(sb_data)
   );

   // Output buffer: a modulator stall loses no byte.
   dtf_skid #(.W(9)) u_tx_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .s_valid(emit),
      .s_ready(ob_ready),
      .s_data({emit_sop, emit_byte}),
      .m_valid(tx_valid),
      .m_ready(tx_ready),
      .m_data(tx_word)
   );

   assign tx_data = tx_word[7:0];
   assign tx_sop = tx_word[8];

   // ---------------------------------------------------------------------
   // Framer state
   // ---------------------------------------------------------------------
   dtf_state_t r;
   dtf_state_t next_r;
   logic advance;

   // Chooses each byte, consumes inputs and steps through the packet.
   always_comb begin
      next_r = r;
      emit = 1'b0;
      emit_byte = `DTF_STUFF_BYTE;
      emit_sop = (r.idx == 8'h00);
      mb_take = 1'b0;
      sb_take = 1'b0;
      // The master clock count runs freely; ticks arrive synchronously.
      if (mclk_tick) begin
         next_r.ts_cnt = r.ts_cnt + 32'h0000_0001;
      end
      unique case (r.kind)
         DTF_KIND_SVC: begin
            emit = sb_valid;
            emit_byte = sb_data[7:0];
            sb_take = sb_valid && ob_ready;
         end
         DTF_KIND_NULL: begin
            emit = 1'b1;
            if (r.idx <= HDR_LAST) begin
               emit_byte = hdr_byte(r.idx[1:0], `DTF_NULL_PID, 1'b0, 4'h0);
            end
         end
         DTF_KIND_MAC: begin
            if (r.idx <= HDR_LAST) begin
               emit = 1'b1;
               emit_byte = hdr_byte(r.idx[1:0], `DTF_MAC_PID, r.payload_start_flag, r.cc);
            end else if (r.idx == PTR_IDX && r.payload_start_flag) begin
               // Frames start right here or after stuff bytes: pointer is zero.
               emit = 1'b1;
               emit_byte = `DTF_PTR_ZERO;
            end else if (r.in_frame || (!r.no_start && mb_valid)) begin
               // Frame bytes go out only as they arrive; a frame is split only at packet boundaries.
               emit = mb_valid;
               emit_byte = mb_data[7:0];
               mb_take = mb_valid && ob_ready;
            end else begin
               emit = 1'b1;
               emit_byte = `DTF_STUFF_BYTE;
            end
            // Timestamp bytes carry the count as it stands at hand-over.
            if (mb_take && r.ts_left != 2'd0) begin
               emit_byte = r.ts_shift[23:16];
               next_r.ts_shift = {r.ts_shift[15:0], 8'h00};
               next_r.ts_left = r.ts_left - 2'd1;
            end else if (mb_take && mb_data[8]) begin
               emit_byte = r.ts_cnt[31:24];
               next_r.ts_shift = r.ts_cnt[23:0];
               next_r.ts_left = 2'd3;
            end
            if (mb_take) begin
               next_r.in_frame = !mb_data[9];
               // Packets without a pointer may not start a new frame.
               if (mb_data[9] && !r.payload_start_flag) begin
                  next_r.no_start = 1'b1;
               end
            end
         end
         default: begin
            next_r.kind = DTF_KIND_NULL; // An illegal kind falls back to a null packet.
         end
      endcase
      advance = emit && ob_ready;
      // Step the byte index and pick the next packet at the boundary.
      if (advance) begin
         if (r.idx == LAST_IDX) begin
            next_r.idx = 8'h00;
            if (r.kind == DTF_KIND_MAC) begin
               next_r.cc = r.cc + 4'h1;
            end
            next_r.no_start = 1'b0;
            if (next_r.in_frame || mb_valid) begin
               next_r.kind = DTF_KIND_MAC;
               next_r.payload_start_flag = !next_r.in_frame;
            end else if (svc_enable && sb_valid && sb_data[8]) begin
               next_r.kind = DTF_KIND_SVC;
            end else begin
               next_r.kind = DTF_KIND_NULL;
            end
         end else begin
            next_r.idx = r.idx + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------
   // Reset starts a null packet so the stream begins on a boundary.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '{kind: DTF_KIND_NULL, default: '0};
      end else begin
         r <= next_r;
      end
   end

endmodule : dtf_framer

// file: hdl/dtf_map.svh
`ifndef DTF_MAP_SVH
`define DTF_MAP_SVH

// ----------------------------------------------------------------------
// Transport packet layout
// ----------------------------------------------------------------------
`define DTF_PKT_LEN 188
`define DTF_HDR_LEN 4
`define DTF_PAYLOAD_LEN 184
`define DTF_PTR_POS 4
`define DTF_SYNC_BYTE 8'h47
`define DTF_MAC_PID 13'h1ffe
`define DTF_NULL_PID 13'h1fff
`define DTF_AFC_PAYLOAD_ONLY 2'b01
`define DTF_SCRAMBLE_OFF 2'b00
`define DTF_PRIORITY_OFF 1'b0
`define DTF_TEI_OFF 1'b0
`define DTF_STUFF_BYTE 8'hff
`define DTF_PTR_ZERO 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTF_SYS_CLK_HZ 100000000
`define DTF_MASTER_CLK_HZ 10240000
`define DTF_JITTER_NS 500
`define DTF_TS_WIDTH 32

`endif

// file: hdl/dtf_pkg.sv
package dtf_pkg;

   // -------------------------------------------------------------------
   // Kind of packet being emitted
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      DTF_KIND_MAC,
      DTF_KIND_NULL,
      DTF_KIND_SVC
   } dtf_kind_t;

   // -------------------------------------------------------------------
   // Framer state
   // -------------------------------------------------------------------
   typedef struct packed {
      dtf_kind_t kind;
      logic [7:0] idx;
      logic [3:0] cc;
      logic payload_start_flag;
      logic in_frame;
      logic no_start;
      logic [31:0] ts_cnt;
      logic [23:0] ts_shift;
      logic [1:0] ts_left;
   } dtf_state_t;

endpackage : dtf_pkg

// file: hdl/dtf_skid.sv
`timescale 1ns/1ns

// Two-entry buffer with registered ready, valid and data.
module dtf_skid #(
   parameter int W = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic s_valid,
   output logic s_ready,
   input wire logic [W-1:0] s_data,
   output logic m_valid,
   input wire logic m_ready,
   output logic [W-1:0] m_data
);
   typedef struct packed {
      logic [W-1:0] main;
      logic [W-1:0] skid;
      logic main_full;
      logic skid_free;
   } dtf_skid_state_t;

   dtf_skid_state_t r;
   dtf_skid_state_t next_r;

   // --------------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------------
   // The head drains or is empty: refill it from the skid entry first.
   always_comb begin
      next_r = r;
      if (m_ready || !r.main_full) begin
         if (!r.skid_free) begin
            next_r.main = r.skid;
            next_r.main_full = 1'b1;
            next_r.skid_free = 1'b1;
         end else begin
            next_r.main = s_data;
            next_r.main_full = s_valid;
         end
      end else if (s_valid && r.skid_free) begin
         next_r.skid = s_data;
         next_r.skid_free = 1'b0;
      end
   end

   // Registers; ready stands high through reset because the skid entry starts free.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r <= '{skid_free: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from the registers.
   assign s_ready = r.skid_free;
   assign m_valid = r.main_full;
   assign m_data = r.main;
endmodule : dtf_skid

// file: tb/downstream_tc_framer_test.sv
`timescale 1ns/1ns

module downstream_tc_framer_test;
   logic sys_clk = 1'b0, sys_rst = 1'b1, mac_ts = 1'b0, mac_eof = 1'b0, mac_valid = 1'b0;
   logic svc_enable = 1'b0, svc_sop = 1'b0, svc_valid = 1'b0, mclk_tick = 1'b0, slow = 1'b0;
   logic [7:0] mac_data = 8'h00, svc_data = 8'h00, tx_data;
   logic mac_ready, svc_ready, tx_sop, tx_valid, tx_ready, done;
   logic [3:0] div = 4'h0;
   logic [31:0] ticks = 32'h0;
   int num_errors = 0;
   int checks = 0;
   always #5 sys_clk = ~sys_clk;
   // Master clock tick every tenth cycle, counted for timestamp bounds.
   always @(posedge sys_clk) begin
      div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
      mclk_tick <= (div == 4'h9);
      ticks <= sys_rst ? 32'h0 : ticks + {31'h0, mclk_tick};
   end
   dtf_framer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .mac_data(mac_data),
      .mac_ts(mac_ts), .mac_eof(mac_eof), .mac_valid(mac_valid), .mac_ready(mac_ready),
      .svc_enable(svc_enable), .svc_data(svc_data), .svc_sop(svc_sop),
      .svc_valid(svc_valid), .svc_ready(svc_ready), .mclk_tick(mclk_tick),
      .tx_data(tx_data), .tx_sop(tx_sop), .tx_valid(tx_valid), .tx_ready(tx_ready));
   dtf_mod_sink i_sink (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .done(done));
   task end_sim;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask : chk_rng
   function automatic logic [7:0] fb(input int k);
      return (k == 0) ? 8'h02 : (k < 5) ? 8'h00 : k[7:0];
   endfunction : fb
   function automatic logic [7:0] fs(input int k);
      return (k == 0) ? 8'h47 : (k == 1) ? 8'h01 : (k < 3) ? 8'h00 : (k == 3) ? 8'h10 : k[7:0];
   endfunction : fs
   task send(input logic svc, input logic [7:0] d, input logic f, input logic e);
      if (svc) begin
         svc_data <= d;
         svc_sop <= f;
         svc_valid <= 1'b1;
      end else begin
         mac_data <= d;
         mac_ts <= f;
         mac_eof <= e;
         mac_valid <= 1'b1;
      end
      for (int n = 0; n < 3000; n++) begin
         @(posedge sys_clk);
         if ((svc ? svc_ready : mac_ready) === 1'b1) return;
      end
      num_errors++;
      end_sim();
   endtask : send
   task wait_pkt(input logic [7:0] id);
      for (int n = 0; n < 3000; n++) begin
         @(posedge sys_clk);
         if (done === 1'b1 && i_sink.pkt[2] === id) return;
      end
      num_errors++;
      end_sim();
   endtask : wait_pkt
   task send_frame(input int len);
      for (int k = 0; k < len; k++) send(1'b0, fb(k), k == 1, k == len - 1);
      mac_valid <= 1'b0;
   endtask : send_frame
   task chk_mac(input logic start, input logic [3:0] cc, input int base, input int len);
      int o;
      int k;
      o = start ? 5 : 4;
      chk8(i_sink.pkt[1], {1'b0, start, 1'b0, 5'h1f});
      chk8(i_sink.pkt[3], {4'h1, cc});
      if (start) chk8(i_sink.pkt[4], 8'h00);
      for (int i = o; i < 188; i++) begin
         k = base + i - o;
         if (k < 1 || k > 4) chk8(i_sink.pkt[i], (k < len) ? fb(k) : 8'hff);
      end
   endtask : chk_mac
   task null_pkt;
      wait_pkt(8'hff);
      chk8(i_sink.pkt[1], 8'h1f);
      chk8(i_sink.pkt[3], 8'h10);
      for (int i = 4; i < 188; i++) chk8(i_sink.pkt[i], 8'hff);
   endtask : null_pkt
   task mac_short;
      logic [31:0] t0;
      t0 = ticks;
      fork
         send_frame(10);
         begin
            wait_pkt(8'hfe);
            chk_mac(1'b1, 4'h0, 0, 10);
            chk_rng({i_sink.pkt[6], i_sink.pkt[7], i_sink.pkt[8], i_sink.pkt[9]},
               t0, ticks + 32'h1);
         end
      join
   endtask : mac_short
   task mac_long;
      logic [31:0] t0;
      t0 = ticks;
      slow <= 1'b1;
      fork
         send_frame(200);
         begin
            wait_pkt(8'hfe);
            chk_mac(1'b1, 4'h1, 0, 200);
            chk_rng({i_sink.pkt[6], i_sink.pkt[7], i_sink.pkt[8], i_sink.pkt[9]},
               t0, ticks);
            wait_pkt(8'hfe);
            chk_mac(1'b0, 4'h2, 183, 200);
         end
      join
   endtask : mac_long
   task svc_pkt;
      svc_enable <= 1'b1;
      fork
         begin
            for (int k = 0; k < 188; k++) send(1'b1, fs(k), k == 0, 1'b0);
            svc_valid <= 1'b0;
         end
         wait_pkt(8'h00);
      join
      for (int i = 0; i < 188; i++) chk8(i_sink.pkt[i], fs(i));
   endtask : svc_pkt
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      null_pkt();
      mac_short();
      mac_long();
      svc_pkt();
      end_sim();
   end
endmodule : downstream_tc_framer_test

// file: tb/dtf_framer_checker.sv
`timescale 1ns/1ns

// Watches the packet stream that leaves the framer.
module dtf_framer_checker (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] tx_data,
   input wire logic tx_sop,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   logic [7:0] cnt;
   logic [7:0] b1;
   logic [7:0] b2;
   logic mac;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   assign mac = (b1[4:0] == 5'h1f);
   // Tracks the byte position and keeps the two identifier bytes.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt <= 8'h00;
      end else if (tx_valid && tx_ready) begin
         cnt <= (cnt == 8'hbb) ? 8'h00 : cnt + 8'h01;
         if (cnt == 8'h01) b1 <= tx_data;
         if (cnt == 8'h02) b2 <= tx_data;
      end
   end
   sop_place_a: assert property (tx_valid && cnt == 8'h00 |-> tx_sop)
      else $error("start flag missing");
   sop_only_a: assert property (tx_valid && tx_sop |-> cnt == 8'h00)
      else $error("start flag misplaced");
   sync_byte_a: assert property (tx_valid && tx_sop |-> tx_data == 8'h47)
      else $error("bad sync byte");
   pid_low_a: assert property (tx_valid && cnt == 8'h02 && mac
      |-> tx_data inside {8'hfe, 8'hff}) else $error("bad identifier");
   hdr_bits_a: assert property (tx_valid && cnt == 8'h03 && mac
      |-> tx_data[7:4] == 4'h1 && !b1[7] && !b1[5]) else $error("bad header bits");
   ptr_zero_a: assert property (tx_valid && cnt == 8'h04 && mac && b2 == 8'hfe && b1[6]
      |-> tx_data == 8'h00) else $error("bad pointer");
   null_fill_a: assert property (tx_valid && cnt > 8'h03 && mac && b2 == 8'hff
      |-> tx_data == 8'hff) else $error("bad fill byte");
   stall_hold_a: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable(tx_data) && $stable(tx_sop)) else $error("stall not held");
   first_pkt_a: assert property ($fell(sys_rst)
      |-> ##[0:4] (tx_valid && tx_sop)) else $error("no packet after reset");
endmodule : dtf_framer_checker

bind dtf_framer dtf_framer_checker i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .tx_data(tx_data), .tx_sop(tx_sop), .tx_valid(tx_valid), .tx_ready(tx_ready));

// file: tb/dtf_mod_sink.sv
`timescale 1ns/1ns

// Modulator side: takes bytes at full or half rate and keeps the packet in progress.
module dtf_mod_sink (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic done
);
   logic [7:0] pkt [188];
   logic [7:0] cnt;
   // Stores each taken byte; done marks the edge that took the last one.
   always_ff @(posedge sys_clk) begin
      done <= 1'b0;
      if (sys_rst) begin
         tx_ready <= 1'b0;
         cnt <= 8'h00;
      end else begin
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready) begin
            pkt[cnt] <= tx_data;
            cnt <= (cnt == 8'hbb) ? 8'h00 : cnt + 8'h01;
            done <= (cnt == 8'hbb);
         end
      end
   end
endmodule : dtf_mod_sink
